/* File: src/spi_ram_pkg.sv */
/*
  shared constants for the serial word access port: frame layout,
  command encodings, synchroniser depth and host timing defaults.
  assumes both ends and the command fifo are built from these values.
*/
package spi_ram_pkg;
  localparam int         ADDR_BITS      = 6;
  localparam int         WORD_BITS      = 24;
  localparam int         RAM_WORDS      = 64;
  localparam int         FRAME_BYTES    = 5;
  localparam int         FRAME_BITS     = 40;
  localparam logic [7:0] CMD_BYTE       = 8'h01;
  localparam logic [1:0] OP_READ        = 2'h0;
  localparam logic [1:0] OP_WRITE       = 2'h2;
  localparam int         ADDR_LSB       = 2;
  // byte positions inside a frame
  localparam logic [2:0] BYTE_CMD       = 3'h0;
  localparam logic [2:0] BYTE_ADDR      = 3'h1;
  localparam logic [2:0] BYTE_DHI       = 3'h2;
  localparam logic [2:0] BYTE_DMID      = 3'h3;
  localparam logic [2:0] BYTE_DLO       = 3'h4;
  localparam logic [2:0] BYTE_DONE      = 3'h5;
  localparam logic [2:0] BIT_LAST       = 3'h7;
  // queued host command word: write flag, address, data
  localparam int         CMD_W          = 31;
  localparam int         CMD_WR_POS     = 30;
  localparam int         CMD_ADDR_POS   = 24;
  // timing: core period in ns, serial clock half periods in core clock cycles
  localparam int         CORE_PERIOD_NS = 20;
  localparam int         SCK_HALF_DEF   = 8;
  localparam int         SCK_HALF_MIN   = 6;
  localparam int         CMD_FIFO_DEPTH = 32;

  // a pin change counts once the second and third stages agree
  function automatic logic settled(input logic [2:0] s);
    return s[1] == s[2];
  endfunction
endpackage

/* File: src/spi_link_if.sv */
/*
  serial link between the host end and the device end.
  assumes a pull-up on the returned data line; the released line reads
  as that pull-up's level here, so no bench resistor is needed.
*/
`timescale 1ns/1ps
interface spi_link_if;
  logic slave_select_n;
  logic serial_clk;
  logic serial_in;
  logic serial_out_drv;
  logic serial_out_oe;
  wire  serial_out;

  // a released line settles at its pull-up level, so the host reads high
  assign serial_out = serial_out_oe ? serial_out_drv : 1'b1;

  modport host (
    output slave_select_n,
    output serial_clk,
    output serial_in,
    input  serial_out
  );
  modport device (
    input  slave_select_n,
    input  serial_clk,
    input  serial_in,
    output serial_out_drv,
    output serial_out_oe
  );
endinterface

/* File: src/cmd_fifo.sv */
/*
  synchronous fifo with valid/ready on both sides and registered flags.
  assumes one clock; depth must be a power of two of at least two.
*/
`timescale 1ns/1ps
module cmd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("cmd_fifo depth must be a power of two, at least two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [CW-1:0]    count_r;
  logic [CW-1:0]    count_nxt;
  logic             push;
  logic             pop;

  assign push       = i_in_valid & o_in_ready;
  assign pop        = o_out_valid & i_out_ready;
  assign o_out_data = mem[rd_ptr_r];

  // occupancy follows push and pop; both at once leaves it unchanged
  always_comb begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + CW'(1);
    end else if (pop && !push) begin
      count_nxt = count_r - CW'(1);
    end
  end

  // flags are registered so the ready seen upstream is a flop
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_r    <= '0;
      rd_ptr_r    <= '0;
      count_r     <= '0;
      o_in_ready  <= 1'b1;
      o_out_valid <= 1'b0;
    end else if (i_ce) begin
      if (push) wr_ptr_r <= wr_ptr_r + PW'(1);
      if (pop) rd_ptr_r <= rd_ptr_r + PW'(1);
      count_r     <= count_nxt;
      o_in_ready  <= count_nxt != CW'(DEPTH);
      o_out_valid <= count_nxt != '0;
    end
  end

  // storage needs no reset; reads are gated by the valid flag
  always_ff @(posedge i_core_clk) begin
    if (i_ce && push) begin
      mem[wr_ptr_r] <= i_in_data;
    end
  end
endmodule

/* File: src/spi_ram_host.sv */
/*
  host end: queues word reads and writes, frames them on the serial link
  and returns read words. the serial clock is divided from the core clock.
  assumes the device end answers with the sampling latency of a
  three-stage synchroniser on each side.
*/
`timescale 1ns/1ps
module spi_ram_host
  import spi_ram_pkg::*;
#(
  parameter int HALF_CYC   = SCK_HALF_DEF,
  parameter int FIFO_DEPTH = CMD_FIFO_DEPTH
) (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_ce,
  input  wire logic                 i_cmd_valid,
  output logic                      o_cmd_ready,
  input  wire logic                 i_cmd_write,
  input  wire logic [ADDR_BITS-1:0] i_cmd_addr,
  input  wire logic [WORD_BITS-1:0] i_cmd_wdata,
  output logic                      o_rsp_valid,
  output logic [WORD_BITS-1:0]      o_rsp_data,
  spi_link_if.host                  link
);
  if (HALF_CYC < SCK_HALF_MIN) begin : g_bad_half
    $error("spi_ram_host half period too short for the synchronisers");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_HOLD, ST_GAP
  } host_state_t;

  localparam int DW = $clog2(HALF_CYC);

  host_state_t           state_r;
  logic [DW-1:0]         div_r;
  logic [5:0]            bit_cnt_r;
  logic [FRAME_BITS-1:0] frame_r;
  logic [WORD_BITS-1:0]  rx_r;
  logic                  is_rd_r;
  logic                  cs_n_r;
  logic                  sck_r;
  logic                  mosi_r;
  logic [2:0]            mi_s_r;
  logic                  mi_f_r;
  logic                  q_valid;
  logic [CMD_W-1:0]      q_data;
  logic                  tick;

  cmd_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) u_queue (
    .i_core_clk  (i_core_clk),
    .i_rst       (i_rst),
    .i_ce        (i_ce),
    .i_in_valid  (i_cmd_valid),
    .o_in_ready  (o_cmd_ready),
    .i_in_data   ({i_cmd_write, i_cmd_addr, i_cmd_wdata}),
    .o_out_valid (q_valid),
    .i_out_ready (state_r == ST_IDLE),
    .o_out_data  (q_data)
  );

  assign link.slave_select_n = cs_n_r;
  assign link.serial_clk     = sck_r;
  assign link.serial_in      = mosi_r;
  assign tick                = div_r == DW'(HALF_CYC - 1);

  // returned data is a pin from the far end: three stages, then agree
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      mi_s_r <= 3'h7;
      mi_f_r <= 1'b1;
    end else if (i_ce) begin
      mi_s_r <= {mi_s_r[1:0], link.serial_out};
      if (settled(mi_s_r)) mi_f_r <= mi_s_r[2];
    end
  end

  // half-period divider, restarted at every phase change
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      div_r <= '0;
    end else if (i_ce) begin
      div_r <= (state_r == ST_IDLE || tick) ? '0 : div_r + DW'(1);
    end
  end

  // frame sequencer; idle clock high, data changes while clock is low
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r     <= ST_IDLE;
      bit_cnt_r   <= '0;
      frame_r     <= '0;
      rx_r        <= '0;
      is_rd_r     <= 1'b0;
      cs_n_r      <= 1'b1;
      sck_r       <= 1'b1;
      mosi_r      <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_rsp_data  <= '0;
    end else if (i_ce) begin
      o_rsp_valid <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (q_valid) begin
            is_rd_r   <= ~q_data[CMD_WR_POS];
            frame_r   <= {CMD_BYTE, q_data[CMD_WR_POS-1:CMD_ADDR_POS],
                          q_data[CMD_WR_POS] ? OP_WRITE : OP_READ,
                          q_data[CMD_WR_POS] ? q_data[WORD_BITS-1:0]
                                             : {WORD_BITS{1'b0}}};
            bit_cnt_r <= '0;
            cs_n_r    <= 1'b0;
            state_r   <= ST_SETUP;
          end
        end
        ST_SETUP, ST_HIGH: begin
          if (tick) begin
            if (state_r == ST_HIGH) begin
              rx_r      <= {rx_r[WORD_BITS-2:0], mi_f_r};
              bit_cnt_r <= bit_cnt_r + 6'h01;
            end
            if (state_r == ST_HIGH && bit_cnt_r == 6'(FRAME_BITS - 1)) begin
              state_r <= ST_HOLD; // select held past last bit
            end else begin
              sck_r   <= 1'b0;
              mosi_r  <= frame_r[FRAME_BITS-1];
              frame_r <= {frame_r[FRAME_BITS-2:0], 1'b0};
              state_r <= ST_LOW;
            end
          end
        end
        ST_LOW: begin
          if (tick) begin
            sck_r   <= 1'b1;
            state_r <= ST_HIGH;
          end
        end
        ST_HOLD: begin
          if (tick) begin
            cs_n_r  <= 1'b1;
            mosi_r  <= 1'b0;
            state_r <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (tick) begin
            o_rsp_valid <= is_rd_r;
            // writes leave the last read word standing
            if (is_rd_r) o_rsp_data <= rx_r;
            state_r     <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule

/* File: src/spi_ram_device.sv */
/*
  device end: serial slave giving the host word access to a 64 x 24 RAM,
  plus a local port through which the measurement side reads and writes
  the same RAM. the link pins are sampled by the core clock.
  assumes the host keeps each serial clock level for several core cycles.
*/
// Notes on behaviour
// - device only answers host-clocked frames
// - mode 3: sample rising, change falling
// - every byte moves msb first
// - host holds select through read response
// - host holds select through write data
// - clock pauses keep bit and byte position
// - read frame: 0x01, address, three zeros
// - read: float two bytes, then word
// - write frame: 0x01, address with op 2
// - output floats for the whole write
// - word address is six bits
// - words are 24 bits, three bytes
// - completed write updates addressed word directly
// - read returns current word directly
`timescale 1ns/1ps
module spi_ram_device
  import spi_ram_pkg::*;
(
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_ce,
  input  wire logic [ADDR_BITS-1:0] i_loc_addr,
  input  wire logic                 i_loc_we,
  input  wire logic [WORD_BITS-1:0] i_loc_wdata,
  output logic [WORD_BITS-1:0]      o_loc_rdata,
  output logic                      o_wr_strobe,
  output logic [ADDR_BITS-1:0]      o_wr_addr,
  output logic [WORD_BITS-1:0]      o_wr_data,
  spi_link_if.device                link
);
  logic [WORD_BITS-1:0] ram [RAM_WORDS];

  logic [2:0]           cs_s_r;
  logic [2:0]           ck_s_r;
  logic [2:0]           di_s_r;
  logic                 cs_f_r;
  logic                 ck_f_r;
  logic                 di_f_r;

  logic [2:0]           bit_cnt_r;
  logic [2:0]           byte_cnt_r;
  logic [6:0]           shift_r;
  logic                 cmd_ok_r;
  logic [ADDR_BITS-1:0] addr_r;
  logic [1:0]           op_r;
  logic [15:0]          wdata_r;
  logic [WORD_BITS-1:0] tx_r;
  logic                 rd_act_r;
  logic                 do_r;
  logic                 oe_r;

  logic                 sck_rise;
  logic                 sck_fall;
  logic                 in_frame;
  logic                 byte_done;
  logic [7:0]           byte_in;
  logic                 wr_commit;
  logic                 rd_start;

  assign link.serial_out_drv = do_r;
  assign link.serial_out_oe  = oe_r;

  // every link pin is asynchronous to the core clock: three stages each
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cs_s_r <= 3'h7;
      ck_s_r <= 3'h7;
      di_s_r <= 3'h0;
    end else if (i_ce) begin
      cs_s_r <= {cs_s_r[1:0], link.slave_select_n};
      ck_s_r <= {ck_s_r[1:0], link.serial_clk};
      di_s_r <= {di_s_r[1:0], link.serial_in};
    end
  end

  // filtered levels move only when stages two and three agree
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cs_f_r <= 1'b1;
      ck_f_r <= 1'b1;
      di_f_r <= 1'b0;
    end else if (i_ce) begin
      if (settled(cs_s_r)) cs_f_r <= cs_s_r[2];
      if (settled(ck_s_r)) ck_f_r <= ck_s_r[2];
      if (settled(di_s_r)) di_f_r <= di_s_r[2];
    end
  end

  // edges are found on the filtered clock, so a paused clock gives none
  assign sck_rise  = settled(ck_s_r) & ck_s_r[2] & ~ck_f_r;
  assign sck_fall  = settled(ck_s_r) & ~ck_s_r[2] & ck_f_r;
  assign in_frame  = ~cs_f_r;
  assign byte_in   = {shift_r, di_f_r};
  assign byte_done = sck_rise & in_frame & (bit_cnt_r == BIT_LAST)
                   & (byte_cnt_r < BYTE_DONE);

  // a write lands only on the last bit of a well-formed write frame
  assign wr_commit = byte_done & (byte_cnt_r == BYTE_DLO)
                   & cmd_ok_r & (op_r == OP_WRITE);
  // a read is armed at the end of the address byte
  assign rd_start  = byte_done & (byte_cnt_r == BYTE_ADDR)
                   & cmd_ok_r & (byte_in[1:0] == OP_READ);

  // bit and byte position; held between edges, cleared on deselect
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      bit_cnt_r  <= '0;
      byte_cnt_r <= '0;
      shift_r    <= '0;
    end else if (i_ce) begin
      if (!in_frame) begin
        bit_cnt_r  <= '0;
        byte_cnt_r <= '0;
      end else if (sck_rise && byte_cnt_r < BYTE_DONE) begin
        shift_r   <= byte_in[6:0];
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (bit_cnt_r == BIT_LAST) byte_cnt_r <= byte_cnt_r + 3'h1;
      end
    end
  end

  // command, address and upper data bytes are captured as they complete
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cmd_ok_r <= 1'b0;
      addr_r   <= '0;
      op_r     <= '0;
      wdata_r  <= '0;
    end else if (i_ce) begin
      if (!in_frame) begin
        cmd_ok_r <= 1'b0;
      end else if (byte_done) begin
        case (byte_cnt_r)
          BYTE_CMD:  cmd_ok_r <= byte_in == CMD_BYTE;
          BYTE_ADDR: begin
            addr_r <= byte_in[7:ADDR_LSB];
            op_r   <= byte_in[1:0];
          end
          BYTE_DHI:  wdata_r[15:8] <= byte_in;
          BYTE_DMID: wdata_r[7:0]  <= byte_in;
          default:   cmd_ok_r <= cmd_ok_r;
        endcase
      end
    end
  end

  // RAM: the serial write wins over a local write in the same cycle
  always_ff @(posedge i_core_clk) begin
    if (i_ce) begin
      if (wr_commit) begin
        ram[addr_r] <= {wdata_r, byte_in};
      end else if (i_loc_we) begin
        ram[i_loc_addr] <= i_loc_wdata;
      end
      o_loc_rdata <= ram[i_loc_addr];
    end
  end

  // notice to the measurement side that the host changed a word
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wr_strobe <= 1'b0;
      o_wr_addr   <= '0;
      o_wr_data   <= '0;
    end else if (i_ce) begin
      o_wr_strobe <= wr_commit;
      if (wr_commit) begin
        o_wr_addr <= addr_r;
        o_wr_data <= {wdata_r, byte_in};
      end
    end
  end

  // response shifter: the word is copied from RAM at the address byte,
  // so the host sees the word as it stood at that moment, not later
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_r     <= '0;
      rd_act_r <= 1'b0;
      do_r     <= 1'b0;
      oe_r     <= 1'b0;
    end else if (i_ce) begin
      if (!in_frame) begin
        rd_act_r <= 1'b0;
        oe_r     <= 1'b0;
      end else if (rd_start) begin
        tx_r     <= ram[byte_in[7:ADDR_LSB]];
        rd_act_r <= 1'b1;
      end else if (sck_fall) begin
        if (rd_act_r && byte_cnt_r >= BYTE_DHI
            && byte_cnt_r <= BYTE_DLO) begin
          oe_r <= 1'b1;
          do_r <= tx_r[WORD_BITS-1];
          tx_r <= {tx_r[WORD_BITS-2:0], 1'b0};
        end else begin
          oe_r <= 1'b0;
        end
      end
    end
  end
endmodule

/* File: verification/spi_link_props.sv */
/*
  concurrent checks on the serial link between the host and device ends.
  assumes the host end drives the link from the same core clock, so the
  raw pins can be sampled directly without a synchroniser.
*/
`timescale 1ns/1ps
module spi_link_props
  import spi_ram_pkg::*;
(
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  input  wire logic slave_select_n,
  input  wire logic serial_clk,
  input  wire logic serial_in,
  input  wire logic serial_out_drv,
  input  wire logic serial_out_oe
);
  logic        sclk_r;
  logic [5:0]  bit_cnt_r;
  logic [15:0] hdr_r;
  logic        rise;
  logic        rd_f;
  logic        wr_f;

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  // raw pin edge, so this count runs ahead of the device's filter
  assign rise = serial_clk && !sclk_r;
  assign rd_f = hdr_r[15:8] == CMD_BYTE && hdr_r[1:0] == OP_READ;
  assign wr_f = hdr_r[15:8] == CMD_BYTE && hdr_r[1:0] == OP_WRITE;

  // previous clock level for edge finding
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) sclk_r <= 1'b1;
    else sclk_r <= serial_clk;
  end

  // rising edges inside one selection; cleared while deselected
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) bit_cnt_r <= 6'h00;
    else if (slave_select_n) bit_cnt_r <= 6'h00;
    else if (rise) bit_cnt_r <= bit_cnt_r + 6'h01;
  end

  // command and address bytes, frozen once both are in
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) hdr_r <= 16'h0000;
    else if (slave_select_n) hdr_r <= 16'h0000;
    else if (rise && bit_cnt_r < 6'h10) hdr_r <= {hdr_r[14:0], serial_in};
  end

  a_clock_idles_high: assert property (slave_select_n |-> serial_clk)
    else $error("serial clock low while deselected");
  a_out_moves_low: assert property (
    $changed(serial_out_drv) && serial_out_oe |-> !serial_clk)
    else $error("returned data changed while clock high");
  a_in_moves_low: assert property (
    $changed(serial_in) && !slave_select_n && bit_cnt_r < 6'h27
    |-> !serial_clk)
    else $error("sent data changed while clock high");
  a_low_level_len: assert property (
    $fell(serial_clk) |-> (!serial_clk)[*4])
    else $error("clock low level too short");
  a_cmd_floats: assert property (
    !slave_select_n && bit_cnt_r < 6'h10 |-> !serial_out_oe)
    else $error("output driven during command bytes");
  a_write_floats: assert property (
    !slave_select_n && wr_f |-> !serial_out_oe)
    else $error("output driven during a write");
  a_read_drives: assert property (
    !slave_select_n && rd_f && bit_cnt_r > 6'h10 |-> serial_out_oe)
    else $error("output not driven in read data bytes");
  a_frame_forty: assert property (
    $rose(slave_select_n) |-> bit_cnt_r == 6'h28)
    else $error("select released away from bit forty");
  a_cmd_byte_first: assert property (
    !slave_select_n && bit_cnt_r == 6'h08 |-> hdr_r[7:0] == CMD_BYTE)
    else $error("first byte is not the command byte");
  a_idle_no_drive: assert property (
    slave_select_n[*6] |-> !serial_out_oe)
    else $error("output driven outside a frame");

  c_read_frame: cover property (rd_f && bit_cnt_r == 6'h28);
  c_write_frame: cover property (wr_f && bit_cnt_r == 6'h28);
  c_drive_start: cover property ($rose(serial_out_oe));
endmodule

/* File: verification/tb.sv */
/*
  testbench: host and device face each other on one link; a second
  device is driven by the bench at a 160 ns link clock to break rules.
  assumes the carrier shows a released returned line at its pull-up level.
*/
`timescale 1ns/1ps
module tb
  import spi_ram_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce_h = 1'b1;
  logic        cmd_valid = 1'b0;
  logic        cmd_write = 1'b0;
  logic [5:0]  cmd_addr = 6'h00;
  logic [23:0] cmd_wdata = 24'h000000;
  logic        cmd_ready, rsp_valid, wr_stb, wr_stb2;
  logic [23:0] rsp_data, wr_data, wr_data2, loc_rdata, loc_rdata2, rd;
  logic [5:0]  wr_addr, wr_addr2;
  logic [5:0]  loc_addr = 6'h00;
  logic [23:0] loc_wdata = 24'h000000;
  logic        loc_we = 1'b0;
  logic        loc_we2 = 1'b0;
  logic [39:0] oe;
  logic [23:0] rsp_q[$];
  int          wr_cnt[2] = '{0, 0};
  int          n_errors = 0;
  int          total_checks = 0;
  int          acc, k;

  spi_link_if lnk ();
  spi_link_if lnk2 ();

  always #10 clk = ~clk;

  spi_ram_host #(.HALF_CYC(SCK_HALF_DEF), .FIFO_DEPTH(CMD_FIFO_DEPTH))
  spi_ram_host_i (.i_core_clk(clk), .i_rst(rst), .i_ce(ce_h),
    .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready),
    .i_cmd_write(cmd_write), .i_cmd_addr(cmd_addr),
    .i_cmd_wdata(cmd_wdata), .o_rsp_valid(rsp_valid),
    .o_rsp_data(rsp_data), .link(lnk));
  spi_ram_device spi_ram_device_i (.i_core_clk(clk), .i_rst(rst),
    .i_ce(1'b1), .i_loc_addr(loc_addr), .i_loc_we(loc_we),
    .i_loc_wdata(loc_wdata), .o_loc_rdata(loc_rdata),
    .o_wr_strobe(wr_stb), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
    .link(lnk));
  spi_ram_device spi_ram_device_i2 (.i_core_clk(clk), .i_rst(rst),
    .i_ce(1'b1), .i_loc_addr(loc_addr), .i_loc_we(loc_we2),
    .i_loc_wdata(loc_wdata), .o_loc_rdata(loc_rdata2),
    .o_wr_strobe(wr_stb2), .o_wr_addr(wr_addr2), .o_wr_data(wr_data2),
    .link(lnk2));
  spi_link_props spi_link_props_i (.i_core_clk(clk), .i_rst(rst),
    .slave_select_n(lnk.slave_select_n), .serial_clk(lnk.serial_clk),
    .serial_in(lnk.serial_in), .serial_out_drv(lnk.serial_out_drv),
    .serial_out_oe(lnk.serial_out_oe));

  // mid-cycle sampling keeps one-cycle pulses clear of edge races
  always @(negedge clk) begin
    if (rsp_valid === 1'b1) rsp_q.push_back(rsp_data);
    if (wr_stb === 1'b1) wr_cnt[0]++;
    if (wr_stb2 === 1'b1) wr_cnt[1]++;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic fail_out(input string s);
    n_errors++;
    $display("mismatch at %0t: timed out waiting for %s", $time, s);
    complete_run();
  endtask

  task automatic chk(input logic [23:0] got, exp, input string s);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // valid is left high so commands can follow back to back
  task automatic host_cmd(input logic w, input logic [5:0] a,
                          input logic [23:0] d);
    int i;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    for (i = 0; i < 40000 && cmd_ready !== 1'b1; i++) tick(1);
    if (i >= 40000) fail_out("command ready");
    tick(1);
  endtask

  task automatic pop_rsp(input logic [23:0] e);
    int i;
    for (i = 0; i < 3000 && rsp_q.size() == 0; i++) tick(1);
    if (i >= 3000) fail_out("read answer");
    chk(rsp_q.pop_front(), e, "read word");
  endtask

  task automatic wait_wr(input int sel, input int target);
    int i;
    for (i = 0; i < 30000 && wr_cnt[sel] < target; i++) tick(1);
    if (i >= 30000) fail_out("ram write");
  endtask

  task automatic loc_wr(input logic sel, input logic [5:0] a,
                        input logic [23:0] d);
    loc_addr = a;
    loc_wdata = d;
    if (sel) loc_we2 = 1'b1;
    else loc_we = 1'b1;
    tick(1);
    loc_we = 1'b0;
    loc_we2 = 1'b0;
    tick(1);
  endtask

  task automatic loc_chk(input logic sel, input logic [5:0] a,
                         input logic [23:0] e);
    loc_addr = a;
    tick(2);
    chk(sel ? loc_rdata2 : loc_rdata, e, "ram word");
  endtask

  // bench-made link clock, moved just after core edges like all stimulus;
  // data is read at the end of each high level, where it has long settled
  task automatic bframe(input logic [39:0] bits, input int n,
                        input int pause_at);
    int i;
    rd = 24'h000000;
    oe = '0;
    lnk2.slave_select_n = 1'b0;
    #80;
    for (i = 0; i < n; i++) begin
      lnk2.serial_clk = 1'b0;
      lnk2.serial_in = bits[39-i];
      #80 lnk2.serial_clk = 1'b1;
      #80;
      if (i == pause_at) #2000;
      oe[39-i] = lnk2.serial_out_oe;
      rd = {rd[22:0], lnk2.serial_out};
    end
    lnk2.slave_select_n = 1'b1;
    lnk2.serial_in = ~lnk2.serial_in;
    #200;
  endtask

  initial begin
    lnk2.slave_select_n = 1'b1;
    lnk2.serial_clk = 1'b1;
    lnk2.serial_in = 1'b0;
    tick(6);
    rst = 1'b0;
    // test 1: host writes at both ends of the address range
    host_cmd(1'b1, 6'h3f, 24'hc3a5e1);
    cmd_valid = 1'b0;
    wait_wr(0, 1);
    chk({18'h00000, wr_addr}, 24'h00003f, "write address");
    chk(wr_data, 24'hc3a5e1, "write data");
    loc_chk(1'b0, 6'h3f, 24'hc3a5e1);
    host_cmd(1'b1, 6'h00, 24'h800001);
    cmd_valid = 1'b0;
    wait_wr(0, 2);
    loc_chk(1'b0, 6'h00, 24'h800001);
    $display("test 1 done");
    // test 2: reads return what is in the ram now
    loc_wr(1'b0, 6'h05, 24'h3c0ff1);
    host_cmd(1'b0, 6'h05, 24'h000000);
    host_cmd(1'b0, 6'h3f, 24'h000000);
    cmd_valid = 1'b0;
    pop_rsp(24'h3c0ff1);
    pop_rsp(24'hc3a5e1);
    $display("test 2 done");
    // test 3: fill the queue until it refuses, then drain it
    acc = 0;
    cmd_write = 1'b1;
    while (cmd_ready === 1'b1 && acc < 40) begin
      cmd_valid = 1'b1;
      cmd_addr = acc[5:0];
      cmd_wdata = {4{acc[5:0]}};
      tick(1);
      acc++;
    end
    cmd_valid = 1'b0;
    // a full queue plus the one frame already taken by the sequencer
    chk({23'h0, acc == CMD_FIFO_DEPTH + 1}, 24'h000001, "queue depth");
    wait_wr(0, 2 + acc);
    tick(4);
    chk({23'h0, cmd_ready}, 24'h000001, "queue drained");
    for (k = 0; k < acc; k++) loc_chk(1'b0, k[5:0], {4{k[5:0]}});
    $display("test 3 done");
    // test 4: host clock frozen mid-frame, back to back reads
    host_cmd(1'b0, 6'h03, 24'h000000);
    host_cmd(1'b0, 6'h3f, 24'h000000);
    cmd_valid = 1'b0;
    tick(300);
    ce_h = 1'b0;
    tick(500);
    ce_h = 1'b1;
    pop_rsp({4{6'h03}});
    pop_rsp(24'hc3a5e1);
    $display("test 4 done");
    // test 5: bench-driven link, broken and paused frames
    loc_wr(1'b1, 6'h0a, 24'h5a5a5a);
    bframe({CMD_BYTE, 6'h0a, OP_WRITE, 24'hffffff}, 20, 99);
    bframe({8'h03, 6'h0a, OP_WRITE, 24'h123456}, 40, 99);
    tick(10);
    chk(wr_cnt[1][23:0], 24'h000000, "discarded frame");
    loc_chk(1'b1, 6'h0a, 24'h5a5a5a);
    bframe({CMD_BYTE, 6'h0a, OP_READ, 24'h000000}, 40, 20);
    chk(rd, 24'h5a5a5a, "link read");
    chk({8'h00, oe[39:24]}, 24'h000000, "float in command");
    chk(oe[23:0], 24'hffffff, "drive in data");
    bframe({CMD_BYTE, 6'h0a, OP_WRITE, 24'ha1b2c3}, 40, 30);
    chk(oe[23:0] | {8'h00, oe[39:24]}, 24'h000000, "write float");
    wait_wr(1, 1);
    chk({18'h00000, wr_addr2}, 24'h00000a, "link write address");
    chk(wr_data2, 24'ha1b2c3, "link write data");
    loc_chk(1'b1, 6'h0a, 24'ha1b2c3);
    $display("test 5 done");
    complete_run();
  end
endmodule
